/* File: src/pieb_params.svh */
// Function
// - Enable register sits at data address 8Dh
// - Bits 7, 5, 2, 1 read zero, ignore writes
// - Bit 4 enables EEPROM write-done request
// - Bit 3 enables bus collision request
// - Bit 0 enables capture/compare two request
// - Flags set on events regardless of enables
// - EEPROM flag set on done, held until cleared
// - Bus collision flag set on collision event
`ifndef PIEB_PARAMS_SVH
`define PIEB_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define PIEB_ENABLE_INDEX 8'h8D
`define PIEB_FLAGS_INDEX 8'h0D
`define PIEB_ADDR_WIDTH 12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIEB_RESERVED_BIT 6
`define PIEB_EEPROM_BIT 4
`define PIEB_COLLISION_BIT 3
`define PIEB_CCP_TWO_BIT 0

// ----------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------
`define PIEB_ENABLE_WMASK 8'h59
`define PIEB_SOURCE_MASK 8'h19
`define PIEB_ENABLE_RESET 8'h00
`define PIEB_FLAGS_RESET 8'h00

`endif

/* File: src/pieb_pkg.sv */
`include "pieb_params.svh"
`default_nettype none
package pieb_pkg;
    typedef logic [7:0] pieb_byte_type;
    typedef logic [`PIEB_ADDR_WIDTH-1:0] pieb_addr_type;

    function automatic pieb_addr_type pieb_byte_addr(input logic [7:0] index);
        pieb_byte_addr = {2'h0, index, 2'h0};
    endfunction : pieb_byte_addr
endpackage : pieb_pkg
`default_nettype wire

/* File: src/pieb_top.sv */
// Local design decision: the APB interface to the registers.
`include "pieb_params.svh"
`default_nettype none
module pieb_top
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire pieb_pkg::pieb_addr_type paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eepromWriteDone,
    input wire logic busCollision,
    input wire logic captureCompareTwo,
    output logic irqRequest
);
    import pieb_pkg::*;

    // ----------------------------------------------------------------
    // Types and helpers
    // ----------------------------------------------------------------
    typedef enum logic {busIdle, busAnswer} pieb_bus_state_type;

    function automatic logic reg_hit
    (
        input pieb_addr_type addr,
        input pieb_byte_type index
    );
        reg_hit = (addr == pieb_byte_addr(index));
    endfunction : reg_hit

    function automatic logic source_live
    (
        input pieb_byte_type flags,
        input pieb_byte_type enables,
        input logic [2:0] pos
    );
        source_live = flags[pos] & enables[pos];
    endfunction : source_live

    function automatic pieb_byte_type w1c_next
    (
        input pieb_byte_type flags,
        input pieb_byte_type clear,
        input pieb_byte_type set
    );
        // Set wins: an event in the clearing cycle must not be lost
        w1c_next = ((flags & ~clear) | set) & `PIEB_SOURCE_MASK;
    endfunction : w1c_next

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    pieb_bus_state_type busStateQ;
    pieb_bus_state_type busStateD;
    logic readyQ;
    logic readyD;
    logic [31:0] rdataQ;
    logic [31:0] rdataD;
    logic errQ;
    logic errD;
    pieb_byte_type enableQ;
    pieb_byte_type enableD;
    pieb_byte_type flagsQ;
    pieb_byte_type flagsD;
    logic irqQ;
    logic irqD;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One wait state keeps prdata registered without a combinational path
    wire accessPhase = psel & penable;
    wire startAccess = accessPhase & (busStateQ == busIdle);
    wire commit = accessPhase & (busStateQ == busAnswer);
    wire hitEnable = reg_hit(paddr, `PIEB_ENABLE_INDEX);
    wire hitFlags = reg_hit(paddr, `PIEB_FLAGS_INDEX);
    wire mapped = hitEnable | hitFlags;
    wire laneZero = pstrb[0];
    wire writeEnable = commit & pwrite & hitEnable & laneZero;
    wire writeFlags = commit & pwrite & hitFlags & laneZero;
    wire [7:0] wByte = pwdata[7:0];

    // ----------------------------------------------------------------
    // Read data and response
    // ----------------------------------------------------------------
    wire [7:0] readByte = hitEnable ? enableQ : (hitFlags ? flagsQ : 8'h00);
    assign readyD = startAccess;
    assign errD = startAccess & ~mapped;
    assign rdataD = (startAccess & ~pwrite) ? {24'h00_0000, readByte} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Bus state
    // ----------------------------------------------------------------
    always_comb
    begin
        busStateD = busIdle;
        case (busStateQ)
            busIdle:
            begin
                if (accessPhase)
                begin
                    busStateD = busAnswer;
                end
            end
            busAnswer:
            begin
                busStateD = busIdle;
            end
            default:
            begin
                busStateD = busIdle;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Enable register
    // ----------------------------------------------------------------
    // Reserved bit 6 is stored as written; software is expected to keep it clear
    wire [7:0] enableWrite = wByte & `PIEB_ENABLE_WMASK;
    assign enableD = writeEnable ? enableWrite : enableQ;

    // ----------------------------------------------------------------
    // Source flags
    // ----------------------------------------------------------------
    // Events set flags whatever the enables say
    logic [7:0] eventVec;
    always_comb
    begin
        eventVec = 8'h00;
        eventVec[`PIEB_EEPROM_BIT] = eepromWriteDone;
        eventVec[`PIEB_COLLISION_BIT] = busCollision;
        eventVec[`PIEB_CCP_TWO_BIT] = captureCompareTwo;
    end
    wire [7:0] clearVec = writeFlags ? wByte : 8'h00;
    assign flagsD = w1c_next(flagsQ, clearVec, eventVec);

    // ----------------------------------------------------------------
    // Request
    // ----------------------------------------------------------------
    // Built from next state so the registered line follows flags without lag
    wire eepromLive = source_live(flagsD, enableD, 3'(`PIEB_EEPROM_BIT));
    wire collisionLive = source_live(flagsD, enableD, 3'(`PIEB_COLLISION_BIT));
    wire ccpTwoLive = source_live(flagsD, enableD, 3'(`PIEB_CCP_TWO_BIT));
    assign irqD = eepromLive | collisionLive | ccpTwoLive;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busStateQ <= busIdle;
        end
        else
        begin
            busStateQ <= busStateD;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            readyQ <= 1'b0;
            rdataQ <= 32'h0000_0000;
            errQ <= 1'b0;
        end
        else
        begin
            readyQ <= readyD;
            rdataQ <= rdataD;
            errQ <= errD;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enableQ <= `PIEB_ENABLE_RESET;
        end
        else
        begin
            enableQ <= enableD;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flagsQ <= `PIEB_FLAGS_RESET;
        end
        else
        begin
            flagsQ <= flagsD;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqQ <= 1'b0;
        end
        else
        begin
            irqQ <= irqD;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = rdataQ;
    assign pready = readyQ;
    assign pslverr = errQ;
    assign irqRequest = irqQ;
endmodule : pieb_top
`default_nettype wire

/* File: dv/pieb_assertions.sv */
`default_nettype none
module pieb_assertions (input wire logic ref_clk, arst_n, psel, penable, pwrite, pready,
    input wire logic pslverr, eepromWriteDone, busCollision, captureCompareTwo, irqRequest,
    input wire pieb_pkg::pieb_addr_type paddr, input wire logic [31:0] prdata);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge ref_clk); endclocking
default disable iff (!arst_n);
property p_rdy; psel && penable && !pready |=> pready; endproperty
a_rdy: assert property (p_rdy) else $error("late ready");
property p_pulse; pready |=> !pready; endproperty
a_pulse: assert property (p_pulse) else $error("ready stuck");
property p_err; pready |-> pslverr == !(paddr == 12'h234 || paddr == 12'h034); endproperty
a_err: assert property (p_err) else $error("bad error");
property p_rd; pready && !pwrite |-> (prdata & 32'hFFFFFFA6) == 0; endproperty
a_rd: assert property (p_rd) else $error("bad bits");
property p_idle; !pready |-> prdata == 0 && !pslverr; endproperty
a_idle: assert property (p_idle) else $error("stray data");
property p_rst; $rose(arst_n) |-> !irqRequest; endproperty
a_rst: assert property (p_rst) else $error("irq at reset");
property p_set; $rose(irqRequest) |->
    $past(eepromWriteDone || busCollision || captureCompareTwo || pready && pwrite); endproperty
a_set: assert property (p_set) else $error("irq no cause");
property p_clr; $fell(irqRequest) |-> $past(pready && pwrite); endproperty
a_clr: assert property (p_clr) else $error("irq lost");
property p_hold; irqRequest && !(pready && pwrite) |=> irqRequest; endproperty
a_hold: assert property (p_hold) else $error("flag lost");
c_wr: cover property (pready && pwrite);
c_irq: cover property ($rose(irqRequest));
c_err: cover property (pslverr);
endmodule : pieb_assertions
bind pieb_top pieb_assertions u_chk (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
module tb_top;
timeunit 1ns;
timeprecision 1ns;
logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
logic eepromWriteDone = 0, busCollision = 0, captureCompareTwo = 0, irqRequest;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, s = 46698, r;
logic [3:0] pstrb = 0;
logic lane = 1;
logic [7:0] e, fb[3] = '{8'h01, 8'h08, 8'h10};
int n_fail = 0, cmp_count = 0, k;
pieb_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eepromWriteDone(eepromWriteDone),
    .busCollision(busCollision), .captureCompareTwo(captureCompareTwo),
    .irqRequest(irqRequest));
initial forever #50 ref_clk = !ref_clk;
function automatic logic [7:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0] & 8'hBF; // Reserved bit kept clear
endfunction : xs
task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
        n_fail++;
        $display("wrong value %0t got %h exp %h", $time, g, x);
    end
endtask : chk
task automatic test_done;
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask : test_done
// Bounded wait: a hung slave ends the run
task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int i = 0;
    @(posedge ref_clk) {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, 24'h0, d, 3'h0, w & lane};
    @(posedge ref_clk) penable <= 1;
    do @(posedge ref_clk); while (!pready && ++i < 20);
    if (!pready) n_fail++;
    if (!pready) test_done;
    r = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
endtask : apb
initial
begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1;
    apb(12'h234, 1'b0, 8'h00);
    chk(r, 0);
    for (k = 0; k < 6; k++)
    begin
        e = xs();
        apb(12'h234, 1'b1, e | 8'hA6);
        apb(12'h234, 1'b0, 8'h00);
        chk(r, {24'h0, e & 8'h19});
    end
    lane = 0;
    apb(12'h234, 1'b1, 8'h19);
    lane = 1;
    apb(12'h234, 1'b0, 8'h00);
    chk(r, {24'h0, e & 8'h19});
    $display("register test done");
    for (k = 0; k < 3; k++)
    begin
        e = (k == 1) ? 8'h00 : xs() | fb[k];
        apb(12'h234, 1'b1, e);
        @(posedge ref_clk) {eepromWriteDone, busCollision, captureCompareTwo} <= 3'h1 << k;
        @(posedge ref_clk) {eepromWriteDone, busCollision, captureCompareTwo} <= 3'h0;
        apb(12'h034, 1'b0, 8'h00);
        chk(r, {24'h0, fb[k]});
        chk({31'h0, irqRequest}, {31'h0, |(e & fb[k])});
        apb(12'h034, 1'b1, fb[k]);
        @(posedge ref_clk);
        chk({31'h0, irqRequest}, 32'h0);
    end
    $display("event test done");
    captureCompareTwo <= 1;
    apb(12'h034, 1'b1, 8'h01);
    captureCompareTwo <= 0;
    apb(12'h034, 1'b0, 8'h00);
    chk(r, 32'h1);
    apb(12'h034, 1'b1, 8'h01);
    apb(12'h034, 1'b0, 8'h00);
    chk(r, 32'h0);
    apb(12'h238, 1'b1, 8'hFF);
    chk({31'h0, er}, 32'h1);
    apb(12'h238, 1'b0, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(r, 32'h0);
    $display("corner test done");
    test_done;
end
endmodule : tb_top
`default_nettype wire
